// File: tdi_consts.svh
// Constants for the traction drive input interlock.
// Assumes a 50 MHz system clock; switch inputs read 1 when closed.
`ifndef TDI_CONSTS_SVH
`define TDI_CONSTS_SVH

// Clock and time base
`define TDI_CLK_KHZ 50000
`define TDI_TICK_MS 100
`define TDI_ANTICRUSH_MS 1500
`define TDI_TICK_CNT_W 23

// Data widths and demand levels
`define TDI_ADC_W 10
`define TDI_DEM_W 8
`define TDI_DEMAND_FULL 8'hFF
`define TDI_DEMAND_ZERO 8'h00
`define TDI_SCALE_W 18

// Analogue input set-up codes
`define TDI_ANA_ACC_FB 2'h0
`define TDI_ANA_FB_ACC 2'h1
`define TDI_ANA_WIGWAG 2'h2

// Scaler channel indices
`define TDI_CH_ACC 0
`define TDI_CH_FB 1
`define TDI_CH_WFWD 2
`define TDI_CH_WREV 3
`define TDI_CH_NUM 4

`endif

// File: tdi_pkg.sv
// Types shared by the interlock top, its checks, the partner model and the bench.
// Assumes tdi_consts.svh is on the include path.
`include "tdi_consts.svh"

package tdi_pkg;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_INCH,
    ST_ANTICRUSH
  } tdi_state_type;

  // Operator switches, 1 = closed
  typedef struct packed {
    logic fwd;
    logic rev;
    logic foot;
    logic seat;
    logic in5;
    logic in6;
    logic in7;
    logic key;
  } tdi_sw_type;

  // Programmed configuration
  typedef struct packed {
    logic truck_walk;
    logic pair_inch;
    logic pin7_hbk;
    logic [1:0] ana_setup;
    logic [`TDI_ADC_W-1:0] acc_zero;
    logic [`TDI_ADC_W-1:0] acc_full;
    logic [`TDI_ADC_W-1:0] fb_zero;
    logic [`TDI_ADC_W-1:0] fb_full;
    logic [`TDI_ADC_W-1:0] fwd_thr;
    logic [`TDI_ADC_W-1:0] rev_thr;
    logic [`TDI_DEM_W-1:0] lim1;
    logic [`TDI_DEM_W-1:0] lim2;
    logic [`TDI_DEM_W-1:0] third_speed_limit_option;
    logic [`TDI_DEM_W-1:0] inch_speed;
    logic [`TDI_DEM_W-1:0] inch_time;
  } tdi_cfg_type;

endpackage

// File: tdi_scale.sv
// Linear span scaler: one registered demand from one reading.
// Assumes lo/hi settings are static while in use.
`timescale 1ns/1ps
`default_nettype none
`include "tdi_consts.svh"

module tdi_scale (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Span and reading
  input wire logic [`TDI_ADC_W-1:0] i_lo,
  input wire logic [`TDI_ADC_W-1:0] i_hi,
  input wire logic [`TDI_ADC_W-1:0] i_val,
  // Scaled demand
  output logic [`TDI_DEM_W-1:0] o_dem
);

  function automatic logic [`TDI_DEM_W-1:0] frac(input logic [`TDI_ADC_W-1:0] d,
                                                input logic [`TDI_ADC_W-1:0] s);
    logic [`TDI_SCALE_W-1:0] p;
    logic [`TDI_SCALE_W-1:0] q;
    p = `TDI_SCALE_W'(d) * `TDI_SCALE_W'(`TDI_DEMAND_FULL);
    q = p / `TDI_SCALE_W'(s);
    return q[`TDI_DEM_W-1:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Either orientation of span; the divide is never by zero on live paths
  // linear scale, clamped
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      o_dem <= `TDI_DEMAND_ZERO;
    else if (i_hi >= i_lo)
    begin
      if (i_val <= i_lo)
        o_dem <= `TDI_DEMAND_ZERO;
      else if (i_val >= i_hi)
        o_dem <= `TDI_DEMAND_FULL;
      else
        o_dem <= frac(i_val - i_lo, i_hi - i_lo);
    end
    else
    begin
      if (i_val >= i_lo)
        o_dem <= `TDI_DEMAND_ZERO;
      else if (i_val <= i_hi)
        o_dem <= `TDI_DEMAND_FULL;
      else
        o_dem <= frac(i_lo - i_val, i_lo - i_hi);
    end
  end

endmodule // tdi_scale
`default_nettype wire

// File: tdi_interlock.sv
// Vehicle interface decision logic for an AC traction controller.
// Assumes switch and digitised analogue inputs are synchronous to i_clk_sys.
`timescale 1ns/1ps
`default_nettype none
`include "tdi_consts.svh"

module tdi_interlock #(
  parameter int TICK_CYCLES = `TDI_TICK_MS * `TDI_CLK_KHZ
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Operator switches
  input wire tdi_pkg::tdi_sw_type i_sw,
  // Digitised analogue inputs
  input wire logic [`TDI_ADC_W-1:0] i_ana1,
  input wire logic [`TDI_ADC_W-1:0] i_ana2,
  // Configuration
  input wire tdi_pkg::tdi_cfg_type i_cfg,
  // Drive decision
  output logic o_drive_fwd,
  output logic o_drive_rev,
  output logic [`TDI_DEM_W-1:0] o_drive_demand,
  output logic [`TDI_DEM_W-1:0] o_brake_demand,
  output logic [`TDI_DEM_W-1:0] o_speed_limit,
  // Contactor and status
  output logic o_line_contactor,
  output logic o_throttle_fault,
  output logic o_inching,
  output logic o_anticrush
);

  localparam int ANTICRUSH_TICKS = `TDI_ANTICRUSH_MS / `TDI_TICK_MS;

  function automatic logic [`TDI_DEM_W-1:0] dmin(input logic [`TDI_DEM_W-1:0] a,
                                                input logic [`TDI_DEM_W-1:0] b);
    return (a < b) ? a : b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Analogue routing and scaling
  logic wigwag;
  logic swapped;
  logic [`TDI_ADC_W-1:0] ch_lo [`TDI_CH_NUM];
  logic [`TDI_ADC_W-1:0] ch_hi [`TDI_CH_NUM];
  logic [`TDI_ADC_W-1:0] ch_val [`TDI_CH_NUM];
  logic [`TDI_DEM_W-1:0] ch_dem [`TDI_CH_NUM];

  assign wigwag = (i_cfg.ana_setup == `TDI_ANA_WIGWAG);
  assign swapped = (i_cfg.ana_setup == `TDI_ANA_FB_ACC);

  assign ch_lo[`TDI_CH_ACC] = i_cfg.acc_zero;
  assign ch_hi[`TDI_CH_ACC] = i_cfg.acc_full;
  assign ch_val[`TDI_CH_ACC] = swapped ? i_ana2 : i_ana1;
  assign ch_lo[`TDI_CH_FB] = i_cfg.fb_zero;
  assign ch_hi[`TDI_CH_FB] = i_cfg.fb_full;
  assign ch_val[`TDI_CH_FB] = swapped ? i_ana1 : i_ana2;
  // throttle halves outside the dead band
  assign ch_lo[`TDI_CH_WFWD] = i_cfg.fwd_thr;
  assign ch_hi[`TDI_CH_WFWD] = i_cfg.acc_full;
  assign ch_val[`TDI_CH_WFWD] = i_ana2;
  assign ch_lo[`TDI_CH_WREV] = i_cfg.rev_thr;
  assign ch_hi[`TDI_CH_WREV] = i_cfg.acc_zero;
  assign ch_val[`TDI_CH_WREV] = i_ana2;

  genvar g;
  generate
    for (g = 0; g < `TDI_CH_NUM; g++)
    begin : g_scale
      tdi_scale u_scale (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_lo(ch_lo[g]),
        .i_hi(ch_hi[g]),
        .i_val(ch_val[g]),
        .o_dem(ch_dem[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Combinational decisions
  logic fault;
  logic drive_ok;
  logic [`TDI_DEM_W-1:0] acc_dem;
  logic [`TDI_DEM_W-1:0] brk_dem;
  logic req_fwd;
  logic req_rev;
  logic inch_fwd;
  logic inch_rev;
  logic [`TDI_DEM_W-1:0] limit;

  assign fault = wigwag && ((i_cfg.acc_zero >= i_cfg.acc_full) ||
                            (i_cfg.rev_thr > i_cfg.fwd_thr));

  assign drive_ok = i_sw.key && i_sw.seat && !fault && (i_cfg.truck_walk || i_sw.foot);

  always_comb
  begin
    acc_dem = ch_dem[`TDI_CH_ACC];
    brk_dem = ch_dem[`TDI_CH_FB];
    req_fwd = 1'b0;
    req_rev = 1'b0;
    if (wigwag)
    begin
      brk_dem = `TDI_DEMAND_ZERO;
      if (ch_dem[`TDI_CH_WFWD] != `TDI_DEMAND_ZERO)
      begin
        acc_dem = ch_dem[`TDI_CH_WFWD];
        req_fwd = 1'b1;
      end
      else
      begin
        acc_dem = ch_dem[`TDI_CH_WREV];
        req_rev = (ch_dem[`TDI_CH_WREV] != `TDI_DEMAND_ZERO);
      end
    end
    else
    begin
      req_fwd = i_sw.fwd && !i_sw.rev && (acc_dem != `TDI_DEMAND_ZERO);
      req_rev = i_sw.rev && !i_sw.fwd && (acc_dem != `TDI_DEMAND_ZERO);
    end
  end

  // one inch input at a time
  assign inch_fwd = i_cfg.pair_inch && i_sw.in5 && !i_sw.in6;
  assign inch_rev = i_cfg.pair_inch && i_sw.in6 && !i_sw.in5;

  always_comb
  begin
    limit = `TDI_DEMAND_FULL;
    if (!i_cfg.pair_inch && !i_sw.in5)
      limit = dmin(limit, i_cfg.lim1);
    if (!i_cfg.pair_inch && !i_sw.in6)
      limit = dmin(limit, i_cfg.lim2);
    if (!i_cfg.pin7_hbk && !i_sw.in7)
      limit = dmin(limit, i_cfg.third_speed_limit_option);
    if (i_cfg.pin7_hbk && i_sw.in7)
      limit = dmin(limit, i_cfg.third_speed_limit_option);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Time base: 100 ms tick, restarted on every state entry
  logic [`TDI_TICK_CNT_W-1:0] div_r;
  logic [`TDI_DEM_W-1:0] ticks_r;
  logic tick;
  logic belly_r;
  logic belly_rise;
  logic enter;
  tdi_pkg::tdi_state_type state_r;
  tdi_pkg::tdi_state_type state_nxt;

  assign tick = (div_r == `TDI_TICK_CNT_W'(TICK_CYCLES - 1));
  assign enter = (state_nxt != state_r);

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst || enter || tick)
      div_r <= '0;
    else
      div_r <= div_r + 1'b1;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst || enter)
      ticks_r <= `TDI_DEMAND_ZERO;
    else if (tick && (ticks_r != `TDI_DEMAND_FULL))
      ticks_r <= ticks_r + 1'b1;
  end

  // Edge of the anti-crush switch, so a held switch cannot retrigger
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      belly_r <= 1'b0;
    else
      belly_r <= i_sw.foot;
  end

  assign belly_rise = i_sw.foot && !belly_r;

  ////////////////////////////////////////////////////////////////////////////
  // Operating state
  logic ac_fwd_r;
  logic ac_dir;
  logic inch_used_r;

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      tdi_pkg::ST_RUN:
      begin
        // anti-crush only while travelling in pedestrian mode
        if (drive_ok && i_cfg.truck_walk && belly_rise && (o_drive_fwd || o_drive_rev))
          state_nxt = tdi_pkg::ST_ANTICRUSH;
        else if (drive_ok && (inch_fwd || inch_rev) && !req_fwd && !req_rev && !inch_used_r)
          state_nxt = tdi_pkg::ST_INCH;
      end
      tdi_pkg::ST_INCH:
      begin
        // ends on release or inching time
        if (!drive_ok || !(inch_fwd || inch_rev) || (ticks_r >= i_cfg.inch_time))
          state_nxt = tdi_pkg::ST_RUN;
      end
      tdi_pkg::ST_ANTICRUSH:
      begin
        if (!drive_ok || (ticks_r >= `TDI_DEM_W'(ANTICRUSH_TICKS)))
          state_nxt = tdi_pkg::ST_RUN;
      end
      default:
        state_nxt = tdi_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      state_r <= tdi_pkg::ST_RUN;
    else
      state_r <= state_nxt;
  end

  // held inch input must reopen, else inching time never limits
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst || !(inch_fwd || inch_rev))
      inch_used_r <= 1'b0;
    else if ((state_r == tdi_pkg::ST_INCH) && (state_nxt == tdi_pkg::ST_RUN))
      inch_used_r <= 1'b1;
  end

  // Reverse of travel latched at trigger
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      ac_fwd_r <= 1'b0;
    else if ((state_r == tdi_pkg::ST_RUN) && (state_nxt == tdi_pkg::ST_ANTICRUSH))
      ac_fwd_r <= o_drive_rev;
  end

  // Live travel on the trigger cycle; a stale latch must not steer it
  assign ac_dir = (state_r == tdi_pkg::ST_RUN) ? o_drive_rev : ac_fwd_r;

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      o_drive_fwd <= 1'b0;
      o_drive_rev <= 1'b0;
      o_drive_demand <= `TDI_DEMAND_ZERO;
    end
    else if (!drive_ok)
    begin
      o_drive_fwd <= 1'b0;
      o_drive_rev <= 1'b0;
      o_drive_demand <= `TDI_DEMAND_ZERO;
    end
    else
    begin
      case (state_nxt)
        tdi_pkg::ST_ANTICRUSH:
        begin
          o_drive_fwd <= ac_dir;
          o_drive_rev <= ~ac_dir;
          o_drive_demand <= i_cfg.inch_speed;
        end
        tdi_pkg::ST_INCH:
        begin
          o_drive_fwd <= inch_fwd;
          o_drive_rev <= inch_rev;
          o_drive_demand <= i_cfg.inch_speed;
        end
        default:
        begin
          o_drive_fwd <= req_fwd;
          o_drive_rev <= req_rev;
          o_drive_demand <= (req_fwd || req_rev) ? acc_dem : `TDI_DEMAND_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      o_brake_demand <= `TDI_DEMAND_ZERO;
      o_speed_limit <= `TDI_DEMAND_FULL;
      o_throttle_fault <= 1'b0;
      o_inching <= 1'b0;
      o_anticrush <= 1'b0;
    end
    else
    begin
      o_brake_demand <= brk_dem;
      o_speed_limit <= limit;
      o_throttle_fault <= fault;
      o_inching <= drive_ok && (state_nxt == tdi_pkg::ST_INCH);
      o_anticrush <= drive_ok && (state_nxt == tdi_pkg::ST_ANTICRUSH);
    end
  end

  // Coil released on fault as well, so a bad throttle setup never powers up
  // line contactor, key off releases it
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      o_line_contactor <= 1'b0;
    else
      o_line_contactor <= i_sw.key && !fault;
  end

endmodule // tdi_interlock
`default_nettype wire

// File: tdi_assertions.sv
// Concurrent checks on the interlock top ports.
// Assumes one clock domain and the package compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "tdi_consts.svh"

module tdi_assertions #(
  parameter int TICK_CYCLES = 4
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Design inputs
  input wire tdi_pkg::tdi_sw_type i_sw,
  input wire logic [`TDI_ADC_W-1:0] i_ana1,
  input wire logic [`TDI_ADC_W-1:0] i_ana2,
  input wire tdi_pkg::tdi_cfg_type i_cfg,
  // Design outputs
  input wire logic o_drive_fwd,
  input wire logic o_drive_rev,
  input wire logic [`TDI_DEM_W-1:0] o_drive_demand,
  input wire logic [`TDI_DEM_W-1:0] o_brake_demand,
  input wire logic [`TDI_DEM_W-1:0] o_speed_limit,
  input wire logic o_line_contactor,
  input wire logic o_throttle_fault,
  input wire logic o_inching,
  input wire logic o_anticrush
);
  localparam int AC_LEN = (`TDI_ANTICRUSH_MS / `TDI_TICK_MS) * TICK_CYCLES;
  logic drv;
  logic [15:0] ac_cnt_r;
  default clocking @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);
  assign drv = o_drive_fwd || o_drive_rev;
  // Reversal length counter
  always_ff @(posedge i_clk_sys)
    ac_cnt_r <= (i_rst || !o_anticrush) ? 16'h0000 : ac_cnt_r + 16'h0001;
  ////////////////////////////////////////
  sequence s_hit;
    i_cfg.truck_walk && $rose(i_sw.foot) && o_drive_fwd && !o_inching && !o_anticrush
    && i_sw.key && i_sw.seat;
  endsequence
  sequence s_run;
    o_anticrush && o_drive_rev && !o_drive_fwd && o_drive_demand == $past(i_cfg.inch_speed);
  endsequence
  key_off_a: assert property (!i_sw.key |=> !drv && !o_line_contactor)
    else $error("drive with key open");
  seat_off_a: assert property (!i_sw.seat |=> !drv)
    else $error("drive with seat open");
  ride_foot_a: assert property (!i_cfg.truck_walk && !i_sw.foot |=> !drv)
    else $error("ride drive without foot");
  fwd_switch_a: assert property (o_drive_fwd && !o_inching && !o_anticrush
    && $past(i_cfg.ana_setup) != 2'h2 |-> $past(i_sw.fwd) && !$past(i_sw.rev))
    else $error("forward without switch");
  rev_switch_a: assert property (o_drive_rev && !o_inching && !o_anticrush
    && $past(i_cfg.ana_setup) != 2'h2 |-> $past(i_sw.rev) && !$past(i_sw.fwd))
    else $error("reverse without switch");
  fault_set_a: assert property (i_cfg.ana_setup == 2'h2 && (i_cfg.acc_zero >= i_cfg.acc_full
    || i_cfg.rev_thr > i_cfg.fwd_thr) |=> o_throttle_fault && !o_line_contactor && !drv)
    else $error("throttle fault missed");
  pair_limit_a: assert property (!i_cfg.pair_inch && (!i_sw.in5 || !i_sw.in6) |=>
    o_speed_limit <= ($past(i_sw.in5) ? $past(i_cfg.lim2) : $past(i_cfg.lim1)))
    else $error("pair limit missed");
  third_limit_a: assert property (i_sw.in7 == i_cfg.pin7_hbk |=>
    o_speed_limit <= $past(i_cfg.third_speed_limit_option))
    else $error("third limit missed");
  free_limit_a: assert property (i_cfg.pair_inch && i_sw.in7 != i_cfg.pin7_hbk |=>
    o_speed_limit == 8'hFF) else $error("limit without cause");
  crush_start_a: assert property (s_hit |=> s_run)
    else $error("reversal did not start");
  crush_len_a: assert property ($fell(o_anticrush) && !$past(i_rst)
    && $past(i_sw.key) && $past(i_sw.seat) |-> ac_cnt_r inside {[AC_LEN:AC_LEN+1]})
    else $error("reversal length wrong");
  inch_start_a: assert property (i_cfg.pair_inch && $rose(i_sw.in5) && !i_sw.in6
    && !$past(i_sw.in6)
    && !i_sw.fwd && !i_sw.rev && i_sw.key && i_sw.seat && i_sw.foot && i_cfg.ana_setup != 2'h2
    && !o_inching && !o_anticrush |=> o_inching && o_drive_fwd
    && o_drive_demand == $past(i_cfg.inch_speed)) else $error("inch did not start");
endmodule // tdi_assertions

bind tdi_interlock tdi_assertions #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_sw(i_sw), .i_ana1(i_ana1), .i_ana2(i_ana2),
  .i_cfg(i_cfg), .o_drive_fwd(o_drive_fwd), .o_drive_rev(o_drive_rev),
  .o_drive_demand(o_drive_demand), .o_brake_demand(o_brake_demand),
  .o_speed_limit(o_speed_limit), .o_line_contactor(o_line_contactor),
  .o_throttle_fault(o_throttle_fault), .o_inching(o_inching), .o_anticrush(o_anticrush));
`default_nettype wire

// File: tdi_partner.sv
// Operator switch and pedal model facing the interlock.
// Assumes bench requests change just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
`include "tdi_consts.svh"

module tdi_partner (
  // Operator requests
  input wire tdi_pkg::tdi_sw_type i_sw_req,
  input wire logic [`TDI_ADC_W-1:0] i_pot1,
  input wire logic [`TDI_ADC_W-1:0] i_pot2,
  input wire logic i_brake_sw,
  input wire logic [`TDI_ADC_W-1:0] i_fb_full,
  // Vehicle wiring
  output var tdi_pkg::tdi_sw_type o_sw,
  output logic [`TDI_ADC_W-1:0] o_ana1,
  output logic [`TDI_ADC_W-1:0] o_ana2
);
  assign o_sw = i_sw_req;
  assign o_ana1 = i_pot1;
  assign o_ana2 = i_brake_sw ? i_fb_full : i_pot2;
endmodule // tdi_partner
`default_nettype wire

// File: tb.sv
// Self-checking bench for the traction interlock.
// Assumes the partner model feeds the switch and analogue inputs; the bench drives cfg directly.
`timescale 1ns/1ps
`default_nettype none
`include "tdi_consts.svh"

module tb;
  localparam int TK = 4;
  localparam int CFG_W = $bits(tdi_pkg::tdi_cfg_type);
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic bsw = 1'b0;
  logic [`TDI_ADC_W-1:0] p1 = '0;
  logic [`TDI_ADC_W-1:0] p2 = '0;
  logic [`TDI_ADC_W-1:0] a1;
  logic [`TDI_ADC_W-1:0] a2;
  logic [`TDI_ADC_W-1:0] v[10] = '{10'h032, 10'h064, 10'h12C, 10'h1B8, 10'h1C2,
    10'h1F4, 10'h226, 10'h230, 10'h2BC, 10'h3E8};
  tdi_pkg::tdi_sw_type sw = '0;
  tdi_pkg::tdi_sw_type dsw;
  tdi_pkg::tdi_cfg_type cfg = '0;
  logic fwd, rev, lc, flt, inch, ac;
  logic [`TDI_DEM_W-1:0] dem, brk, lim;
  int bad_count = 0;
  int checks = 0;
  int n;

  always #10 i_clk_sys = ~i_clk_sys;

  tdi_partner u_veh (.i_sw_req(sw), .i_pot1(p1), .i_pot2(p2), .i_brake_sw(bsw),
    .i_fb_full(cfg.fb_full), .o_sw(dsw), .o_ana1(a1), .o_ana2(a2));
  tdi_interlock #(.TICK_CYCLES(TK)) dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_sw(dsw),
    .i_ana1(a1), .i_ana2(a2), .i_cfg(cfg), .o_drive_fwd(fwd), .o_drive_rev(rev),
    .o_drive_demand(dem), .o_brake_demand(brk), .o_speed_limit(lim), .o_line_contactor(lc),
    .o_throttle_fault(flt), .o_inching(inch), .o_anticrush(ac));
  ////////////////////////////////////////
  task automatic step(input int k);
    repeat (k) @(posedge i_clk_sys);
    #1;
  endtask

  task automatic cmp(input logic [15:0] got, input int exp, input string m);
    checks++;
    if (got !== 16'(exp))
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, 16'(exp));
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic tmo(input int k);
    if (k >= 200)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t wait ran out", $time);
      end_of_test;
    end
  endtask

  // Span scaling, either orientation
  function automatic int scl(input int x, input int lo, input int hi);
    if (lo <= hi)
      return x <= lo ? 0 : x >= hi ? 255 : (x - lo) * 255 / (hi - lo);
    return x >= lo ? 0 : x <= hi ? 255 : (lo - x) * 255 / (lo - hi);
  endfunction

  task automatic chk;
    int f, r, d, b, l, e, t, ok, pa, pb;
    t = cfg.ana_setup == 2'h2;
    e = t && (cfg.acc_zero >= cfg.acc_full || cfg.rev_thr > cfg.fwd_thr);
    ok = dsw.key && dsw.seat && (cfg.truck_walk || dsw.foot) && !e;
    pa = cfg.ana_setup == 2'h1 ? a2 : a1;
    pb = cfg.ana_setup == 2'h1 ? a1 : a2;
    f = t ? a2 > cfg.fwd_thr : dsw.fwd && !dsw.rev;
    r = t ? a2 < cfg.rev_thr : dsw.rev && !dsw.fwd;
    d = !t ? scl(pa, cfg.acc_zero, cfg.acc_full) :
      f ? scl(a2, cfg.fwd_thr, cfg.acc_full) : scl(a2, cfg.rev_thr, cfg.acc_zero);
    b = t ? 0 : scl(pb, cfg.fb_zero, cfg.fb_full);
    f = f && ok && d > 0;
    r = r && ok && d > 0;
    l = 255;
    if (!cfg.pair_inch && !dsw.in5 && cfg.lim1 < l) l = cfg.lim1;
    if (!cfg.pair_inch && !dsw.in6 && cfg.lim2 < l) l = cfg.lim2;
    if (dsw.in7 == cfg.pin7_hbk && cfg.third_speed_limit_option < l)
      l = cfg.third_speed_limit_option;
    cmp(fwd, f, "fwd");
    cmp(rev, r, "rev");
    cmp(dem, (f || r) ? d : 0, "demand");
    cmp(brk, b, "brake");
    cmp(lim, l, "limit");
    cmp(lc, dsw.key && !e, "contactor");
    cmp(flt, e, "fault");
  endtask
  ////////////////////////////////////////
  initial
  begin
    n = $urandom(98972);
    step(12);
    i_rst = 1'b0;
    repeat (40)
    begin
      cfg = tdi_pkg::tdi_cfg_type'(CFG_W'({$urandom, $urandom, $urandom, $urandom}));
      cfg.truck_walk = 1'b0;
      cfg.pair_inch = 1'b0;
      if (cfg.ana_setup == 2'h2) cfg.ana_setup = 2'h3;
      sw = 8'($urandom) | (($urandom % 4 != 0) ? 8'h31 : 8'h00);
      {p1, p2, bsw} = 21'($urandom);
      step(3);
      chk;
    end
    $display("random mix done");
    cfg = '0;
    cfg.ana_setup = 2'h2;
    {cfg.acc_zero, cfg.acc_full, cfg.fwd_thr, cfg.rev_thr} = {10'h064, 10'h384, 10'h226, 10'h1C2};
    sw = 8'h71;
    foreach (v[i])
    begin
      p2 = v[i];
      step(3);
      chk;
    end
    cfg.rev_thr = 10'h258;
    step(2);
    chk;
    cfg.rev_thr = 10'h1C2;
    cfg.acc_zero = 10'h3E8;
    step(2);
    chk;
    $display("throttle done");
    {cfg.ana_setup, cfg.acc_zero, cfg.fb_zero, cfg.fb_full} = {2'h0, 10'h064, 10'h0C8, 10'h320};
    bsw = 1'b1;
    sw = 8'h31;
    step(3);
    cmp(brk, 255, "switch brake");
    bsw = 1'b0;
    {cfg.pair_inch, cfg.inch_speed, cfg.inch_time} = {1'b1, 8'h40, 8'h03};
    sw = 8'h3B;
    step(1);
    cmp({fwd, inch, dem}, {2'b11, 8'h40}, "inch fwd");
    for (n = 1; inch === 1'b1 && n < 200; n++) step(1);
    tmo(n);
    cmp(n > 3 * TK && n <= 3 * TK + 2, 1, "inch time");
    sw = 8'h33;
    step(2);
    sw = 8'h37;
    step(1);
    cmp({rev, inch, dem}, {2'b11, 8'h40}, "inch rev");
    sw = 8'h33;
    step(2);
    cmp(inch, 0, "inch release");
    $display("inching done");
    {cfg.pair_inch, cfg.truck_walk, cfg.acc_full} = {1'b0, 1'b1, 10'h384};
    p1 = 10'h1F4;
    sw = 8'h91;
    step(3);
    chk;
    sw.foot = 1'b1;
    step(1);
    cmp({ac, rev, fwd, dem}, {3'b110, 8'h40}, "crush start");
    for (n = 1; ac === 1'b1 && n < 200; n++) step(1);
    tmo(n);
    cmp(n > 15 * TK && n <= 15 * TK + 2, 1, "crush time");
    step(3);
    chk;
    sw.foot = 1'b0;
    step(2);
    sw.foot = 1'b1;
    step(1);
    sw.seat = 1'b0;
    step(2);
    cmp(ac, 0, "crush abort");
    i_rst = 1'b1;
    step(2);
    cmp({lc, fwd, ac}, 0, "reset");
    i_rst = 1'b0;
    $display("anti-crush done");
    end_of_test;
  end
endmodule // tb
`default_nettype wire
